// >>> core/uart_frame_if.sv
// Serial line and transfer clock between the transmitter and its partner.
// Assumes each end drives only its own enables; released lines idle.
`default_nettype none
interface uart_frame_if;
    logic txd;
    logic txd_oe;
    logic xck_dev;
    logic xck_dev_oe;
    logic xck_ptn;
    logic xck_ptn_oe;
    logic txd_line;
    logic xck_line;

    // Released serial line is pulled high, released clock low
    assign txd_line = txd_oe ? txd : 1'b1;
    assign xck_line = xck_dev_oe ? xck_dev : (xck_ptn_oe ? xck_ptn : 1'b0);

    modport device (output txd, txd_oe, xck_dev, xck_dev_oe, input xck_line);
    modport partner (output xck_ptn, xck_ptn_oe, input txd_line, xck_line);
endinterface
`default_nettype wire

// >>> core/uart_frame_params.svh
// Constants shared by the serial frame transmitter and its remote partner.
// Assumes both ends include it by bare name from the core folder.
`ifndef UART_FRAME_PARAMS_SVH
`define UART_FRAME_PARAMS_SVH

// Register offsets on the software port
`define UF_OFS_DATA 3'h0
`define UF_OFS_CSA 3'h1
`define UF_OFS_CSB 3'h2
`define UF_OFS_CSC 3'h3
`define UF_OFS_BAUD 3'h4

// control_status_a fields
`define UF_A_COMPLETE 6
`define UF_A_EMPTY 5
`define UF_A_DOUBLE 1
// control_status_b fields
`define UF_B_EMPTY_IE 5
`define UF_B_TX_ENABLE 3
`define UF_B_NINTH 0
// control_status_c fields
`define UF_C_SLAVE 7
`define UF_C_SYNC 6
`define UF_C_PAR_LSB 4
`define UF_C_STOP2 3
`define UF_C_SIZE_LSB 0

// Reset values
`define UF_RST_CSA 8'h00
`define UF_RST_CSB 8'h00
`define UF_RST_CSC 8'h03
`define UF_RST_BAUD 8'h00

// Character size codes and parity codes
`define UF_SIZE_5 3'h0
`define UF_SIZE_6 3'h1
`define UF_SIZE_7 3'h2
`define UF_SIZE_8 3'h3
`define UF_SIZE_9 3'h7
`define UF_PAR_EVEN 2'h2
`define UF_PAR_ODD 2'h3

// Baud ticks per bit in asynchronous normal and double speed mode, minus one
`define UF_TICKS_NORMAL 4'hf
`define UF_TICKS_DOUBLE 4'h7

`endif

// >>> core/uart_frame_partner.sv
// Remote serial partner: receives frames from the transmit line.
// Assumes the same clock as the transmitter and a matching frame format.
`default_nettype none
`include "uart_frame_params.svh"
module uart_frame_partner (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] size_code_i,
    input wire logic [1:0] parity_mode_i,
    input wire logic [7:0] baud_i,
    input wire logic double_speed_i,
    input wire logic sync_mode_i,
    input wire logic clock_master_i,
    output logic [8:0] rx_data_o,
    output logic rx_valid_o,
    output logic frame_error_o,
    output logic parity_error_o,
    uart_frame_if.partner link
);
    uart_frame_pkg::rx_state_t state_r;
    logic [8:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [3:0] nbits;
    logic par_r;
    logic line_prev_r;
    logic xck_prev_r;
    logic xck_r;
    logic [7:0] div_r;
    logic [11:0] cnt_r;
    logic [11:0] period;
    logic sample;
    logic rxd;

    assign rxd = link.txd_line;
    assign period = 12'(({4'h0, baud_i} + 12'h001) << (double_speed_i ? 3 : 4));

    always_comb begin
        unique case (size_code_i)
            `UF_SIZE_5: nbits = 4'd5;
            `UF_SIZE_6: nbits = 4'd6;
            `UF_SIZE_7: nbits = 4'd7;
            `UF_SIZE_8: nbits = 4'd8;
            `UF_SIZE_9: nbits = 4'd9;
            default: nbits = 4'd8;
        endcase
    end

    // Sync mode samples on the falling edge, opposite the change edge
    assign sample = sync_mode_i ? (!link.xck_line && xck_prev_r)
        : (state_r != uart_frame_pkg::RX_IDLE && cnt_r == 12'h000);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xck_r <= 1'b0;
            div_r <= 8'h00;
            xck_prev_r <= 1'b0;
            line_prev_r <= 1'b1;
        end else begin
            xck_prev_r <= link.xck_line;
            line_prev_r <= rxd;
            if (div_r == 8'h00) begin
                div_r <= baud_i;
                xck_r <= !xck_r;
            end else begin
                div_r <= div_r - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= uart_frame_pkg::RX_IDLE;
            cnt_r <= 12'h000;
            shift_r <= 9'h000;
            bit_cnt_r <= 4'h0;
            par_r <= 1'b0;
            rx_data_o <= 9'h000;
            rx_valid_o <= 1'b0;
            frame_error_o <= 1'b0;
            parity_error_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            cnt_r <= (cnt_r == 12'h000) ? period - 12'h001 : cnt_r - 12'h001;
            unique case (state_r)
                uart_frame_pkg::RX_IDLE: begin
                    if (!sync_mode_i && line_prev_r && !rxd) begin
                        state_r <= uart_frame_pkg::RX_START;
                        cnt_r <= {1'b0, period[11:1]} - 12'h002;
                    end else if (sample && !rxd) begin
                        state_r <= uart_frame_pkg::RX_DATA;
                        bit_cnt_r <= 4'h0;
                    end
                end
                uart_frame_pkg::RX_START: begin
                    if (sample) begin
                        state_r <= rxd ? uart_frame_pkg::RX_IDLE : uart_frame_pkg::RX_DATA;
                        bit_cnt_r <= 4'h0;
                    end
                end
                uart_frame_pkg::RX_DATA: begin
                    if (sample) begin
                        shift_r[bit_cnt_r] <= rxd;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == nbits - 4'h1) begin
                            state_r <= parity_mode_i[1] ? uart_frame_pkg::RX_PARITY
                                : uart_frame_pkg::RX_STOP;
                        end
                    end
                end
                uart_frame_pkg::RX_PARITY: begin
                    if (sample) begin
                        par_r <= rxd ^ (parity_mode_i == `UF_PAR_ODD);
                        state_r <= uart_frame_pkg::RX_STOP;
                    end
                end
                uart_frame_pkg::RX_STOP: begin
                    if (sample) begin
                        // Only the first stop bit is looked at; a second passes as idle
                        state_r <= uart_frame_pkg::RX_IDLE;
                        frame_error_o <= !rxd;
                        parity_error_o <= parity_mode_i[1] && (par_r != ^shift_r);
                        rx_data_o <= shift_r;
                        rx_valid_o <= 1'b1;
                        shift_r <= 9'h000;
                    end
                end
            endcase
        end
    end

    assign link.xck_ptn = xck_r;
    assign link.xck_ptn_oe = sync_mode_i && clock_master_i;
endmodule
`default_nettype wire

// >>> core/uart_frame_pkg.sv
// Types shared by the serial frame transmitter and its remote partner.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package uart_frame_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PARITY = 5'b01000,
        TX_STOP = 5'b10000
    } tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PARITY = 5'b01000,
        RX_STOP = 5'b10000
    } rx_state_t;
endpackage
`default_nettype wire

// >>> core/uart_frame_tx.sv
// Serial frame transmitter with software register port and line drivers.
// Assumes one 40 MHz clock; the partner end sits on the far side of link.
//
// Chosen here: the plain strobed port and the address map.
`default_nettype none
`include "uart_frame_params.svh"
module uart_frame_tx (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic buffer_empty_irq_o,
    uart_frame_if.device link
);
    logic [7:0] csa_r;
    logic [7:0] csb_r;
    logic [7:0] csc_r;
    logic [7:0] baud_r;
    logic [7:0] buf_data_r;
    logic buf_full_r;
    logic buf_full_nxt;
    logic complete_r;
    uart_frame_pkg::tx_state_t state_r;
    logic [8:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic parity_r;
    logic second_stop_r;
    logic txd_r;
    logic txd_oe_r;
    logic xck_r;
    logic xck_oe_r;
    logic xck_prev_r;
    logic [7:0] baud_cnt_r;
    logic [3:0] presc_r;
    logic baud_tick;
    logic bit_step;
    logic [3:0] nbits;
    logic [8:0] mask;
    logic [8:0] load_word;
    logic move;
    logic frame_end;
    logic active;
    logic wr_data;

    logic tx_enable;
    logic sync_mode;
    logic slave_mode;
    logic [1:0] parity_mode;
    logic [2:0] size_code;
    assign tx_enable = csb_r[`UF_B_TX_ENABLE];
    assign sync_mode = csc_r[`UF_C_SYNC];
    assign slave_mode = csc_r[`UF_C_SLAVE];
    assign parity_mode = csc_r[`UF_C_PAR_LSB +: 2];
    assign size_code = csc_r[`UF_C_SIZE_LSB +: 3];

    // Writes while disabled are dropped so nothing is stranded in the buffer
    assign wr_data = wr_i && addr_i == `UF_OFS_DATA && tx_enable;

    always_comb begin
        unique case (size_code)
            `UF_SIZE_5: nbits = 4'd5;
            `UF_SIZE_6: nbits = 4'd6;
            `UF_SIZE_7: nbits = 4'd7;
            `UF_SIZE_8: nbits = 4'd8;
            `UF_SIZE_9: nbits = 4'd9;
            default: nbits = 4'd8;
        endcase
    end

    for (genvar i = 0; i < 9; i++) begin : g_mask
        assign mask[i] = 4'(i) < nbits;
    end
    assign load_word = {csb_r[`UF_B_NINTH], buf_data_r} & mask;

    // Bit step: baud divider, then 16 or 8 ticks async, xck edge when sync
    assign baud_tick = baud_cnt_r == 8'h00;
    always_comb begin
        if (!sync_mode) begin
            bit_step = baud_tick && presc_r == (csa_r[`UF_A_DOUBLE] ?
                `UF_TICKS_DOUBLE : `UF_TICKS_NORMAL);
        end else if (slave_mode) begin
            bit_step = link.xck_line && !xck_prev_r;
        end else begin
            bit_step = baud_tick && !xck_r;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            baud_cnt_r <= 8'h00;
            presc_r <= 4'h0;
            xck_r <= 1'b0;
            xck_prev_r <= 1'b0;
        end else begin
            xck_prev_r <= link.xck_line;
            if (wr_i && addr_i == `UF_OFS_BAUD) begin
                baud_cnt_r <= wdata_i;
            end else if (baud_tick) begin
                baud_cnt_r <= baud_r;
            end else begin
                baud_cnt_r <= baud_cnt_r - 8'h01;
            end
            if (bit_step || sync_mode) begin
                presc_r <= 4'h0;
            end else if (baud_tick) begin
                presc_r <= presc_r + 4'h1;
            end
            if (baud_tick && sync_mode && !slave_mode) begin
                xck_r <= !xck_r;
            end
        end
    end

    // Hand-off happens only on a bit step so the start bit is full length
    assign frame_end = bit_step && state_r == uart_frame_pkg::TX_STOP
        && !(csc_r[`UF_C_STOP2] && !second_stop_r);
    assign move = buf_full_r && ((bit_step && state_r == uart_frame_pkg::TX_IDLE)
        || frame_end);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= uart_frame_pkg::TX_IDLE;
            shift_r <= 9'h000;
            bit_cnt_r <= 4'h0;
            parity_r <= 1'b0;
            second_stop_r <= 1'b0;
            txd_r <= 1'b1;
        end else if (move) begin
            state_r <= uart_frame_pkg::TX_START;
            shift_r <= load_word;
            parity_r <= ^load_word ^ (parity_mode == `UF_PAR_ODD);
            bit_cnt_r <= 4'h0;
            txd_r <= 1'b0;
        end else if (bit_step) begin
            unique case (state_r)
                uart_frame_pkg::TX_IDLE: begin
                    txd_r <= 1'b1;
                end
                uart_frame_pkg::TX_START: begin
                    state_r <= uart_frame_pkg::TX_DATA;
                    txd_r <= shift_r[0];
                    shift_r <= {1'b0, shift_r[8:1]};
                    bit_cnt_r <= 4'h1;
                end
                uart_frame_pkg::TX_DATA: begin
                    if (bit_cnt_r != nbits) begin
                        txd_r <= shift_r[0];
                        shift_r <= {1'b0, shift_r[8:1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (parity_mode[1]) begin
                        state_r <= uart_frame_pkg::TX_PARITY;
                        txd_r <= parity_r;
                    end else begin
                        state_r <= uart_frame_pkg::TX_STOP;
                        second_stop_r <= 1'b0;
                        txd_r <= 1'b1;
                    end
                end
                uart_frame_pkg::TX_PARITY: begin
                    state_r <= uart_frame_pkg::TX_STOP;
                    second_stop_r <= 1'b0;
                    txd_r <= 1'b1;
                end
                uart_frame_pkg::TX_STOP: begin
                    if (csc_r[`UF_C_STOP2] && !second_stop_r) begin
                        second_stop_r <= 1'b1;
                    end else begin
                        state_r <= uart_frame_pkg::TX_IDLE;
                    end
                    txd_r <= 1'b1;
                end
            endcase
        end
    end

    // A write landing in the hand-off cycle refills the buffer at once
    assign buf_full_nxt = wr_data || (buf_full_r && !move);
    assign active = tx_enable || buf_full_r || state_r != uart_frame_pkg::TX_IDLE;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buf_full_r <= 1'b0;
            buf_data_r <= 8'h00;
            complete_r <= 1'b0;
        end else begin
            buf_full_r <= buf_full_nxt;
            if (wr_data) begin
                buf_data_r <= wdata_i;
            end
            if (frame_end && !buf_full_r) begin
                complete_r <= 1'b1;
            end else if (wr_i && addr_i == `UF_OFS_CSA && wdata_i[`UF_A_COMPLETE]) begin
                complete_r <= 1'b0;
            end
        end
    end

    // Format bits are shared with the receive side; software keeps them still
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            csa_r <= `UF_RST_CSA;
            csb_r <= `UF_RST_CSB;
            csc_r <= `UF_RST_CSC;
            baud_r <= `UF_RST_BAUD;
        end else if (wr_i) begin
            unique case (addr_i)
                `UF_OFS_CSA: csa_r <= wdata_i & 8'h02;
                `UF_OFS_CSB: csb_r <= wdata_i & 8'h29;
                `UF_OFS_CSC: csc_r <= wdata_i;
                `UF_OFS_BAUD: baud_r <= wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
            buffer_empty_irq_o <= 1'b0;
            txd_oe_r <= 1'b0;
            xck_oe_r <= 1'b0;
        end else begin
            rdata_o <= 8'h00;
            if (rd_i) begin
                unique case (addr_i)
                    `UF_OFS_CSA: rdata_o <= csa_r
                        | (8'(complete_r) << `UF_A_COMPLETE)
                        | (8'(!buf_full_r) << `UF_A_EMPTY);
                    `UF_OFS_CSB: rdata_o <= csb_r;
                    `UF_OFS_CSC: rdata_o <= csc_r;
                    `UF_OFS_BAUD: rdata_o <= baud_r;
                    default: rdata_o <= 8'h00;
                endcase
            end
            buffer_empty_irq_o <= !buf_full_nxt && csb_r[`UF_B_EMPTY_IE];
            txd_oe_r <= active;
            xck_oe_r <= active && sync_mode && !slave_mode;
        end
    end

    assign link.txd = txd_r;
    assign link.txd_oe = txd_oe_r;
    assign link.xck_dev = xck_r;
    assign link.xck_dev_oe = xck_oe_r;
endmodule
`default_nettype wire

// >>> verification/uart_frame_format_transmitter_test.sv
// Bench: transmitter facing its partner, plus a hand-driven line for faults.
// Assumes the core folder on the include path and one 40 MHz clock.
`default_nettype none
`include "uart_frame_params.svh"
module uart_frame_format_transmitter_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq;
    logic [2:0] p_size = 3'h3;
    logic [1:0] p_par = 2'h0;
    logic [7:0] p_baud = 8'h00;
    logic p_dbl = 1'b0;
    logic p_sync = 1'b0;
    logic p_master = 1'b0;
    logic [8:0] rx_data, rx2_data;
    logic rx_valid, fe, pe, fe2, pe2;
    logic [12:0] va, vb;
    logic [2:0] scode [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [1:0] pcode [3] = '{2'h0, 2'h2, 2'h3};
    int fails = 0;
    int tests_run = 0;
    int rx_cnt = 0;
    int k, c0, len;
    uart_frame_if lnk ();
    uart_frame_if bad ();

    uart_frame_tx i_uart_frame_tx (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .buffer_empty_irq_o(irq), .link(lnk));
    uart_frame_partner i_uart_frame_partner (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .size_code_i(p_size), .parity_mode_i(p_par), .baud_i(p_baud), .double_speed_i(p_dbl),
        .sync_mode_i(p_sync), .clock_master_i(p_master), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .frame_error_o(fe), .parity_error_o(pe), .link(lnk));
    // Second receiver sees only the bench's hand-driven frames, one broken and one clean
    uart_frame_partner i_uart_frame_partner_bad (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .size_code_i(p_size), .parity_mode_i(p_par), .baud_i(p_baud), .double_speed_i(p_dbl),
        .sync_mode_i(p_sync), .clock_master_i(p_master), .rx_data_o(rx2_data),
        .rx_valid_o(), .frame_error_o(fe2), .parity_error_o(pe2), .link(bad));
    uart_frame_props i_uart_frame_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .txd(lnk.txd),
        .txd_oe(lnk.txd_oe), .xck_dev(lnk.xck_dev), .xck_dev_oe(lnk.xck_dev_oe),
        .txd_line(lnk.txd_line));

    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check({1'b0, rdata_o}, {1'b0, exp});
    endtask
    task automatic wait_rx(input int c);
        int n;
        n = 0;
        while (rx_cnt == c && n < 4000) begin
            tick(1);
            n++;
        end
        check(9'(n < 4000), 9'h001);
    endtask
    function automatic logic [12:0] frame_bits(input logic [8:0] d, input int n,
            input logic [1:0] par, input logic st2, output int ln);
        logic [12:0] v;
        logic p;
        v = 13'h1ffe;
        p = par[0];
        for (int i = 0; i < n; i++) begin
            v[i + 1] = d[i];
            p = p ^ d[i];
        end
        if (par[1]) v[n + 1] = p;
        ln = n + 2 + int'(par[1]) + int'(st2);
        return v;
    endfunction
    // Samples each bit mid-period; w returns how long the start took to show
    task automatic watch(input logic [12:0] v, input int ln, input int bp, output int w);
        w = 0;
        while (lnk.txd_line !== 1'b0 && w < 3 * bp + 40) begin
            tick(1);
            w++;
        end
        tick(bp / 2);
        for (int i = 0; i < ln; i++) begin
            check({8'h00, lnk.txd_line}, {8'h00, v[i]});
            if (i < ln - 1) tick(bp);
        end
    endtask
    task automatic send(input logic [8:0] d, input logic [7:0] c, input int bp);
        logic [12:0] v;
        int n, ln, w, c1;
        n = (c[2:0] == `UF_SIZE_9) ? 9 : int'(c[2:0]) + 5;
        v = frame_bits(d, n, c[5:4], c[3], ln);
        wr(`UF_OFS_CSC, c);
        p_size <= c[2:0];
        p_par <= c[5:4];
        p_sync <= c[6];
        wr(`UF_OFS_CSB, {7'h04, d[8]});
        c1 = rx_cnt;
        wr(`UF_OFS_DATA, d[7:0]);
        if (bp != 0) watch(v, ln, bp, w);
        wait_rx(c1);
        check(rx_data, d & ~(9'h1ff << n));
        check({7'h00, fe, pe}, 9'h000);
        tick(80);
    endtask
    task automatic raw(input logic [11:0] v);
        @(posedge clk_i);
        for (int i = 0; i < 12; i++) begin
            bad.txd <= v[i];
            repeat (16) @(posedge clk_i);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end
    initial begin
        bad.txd = 1'b1;
        bad.txd_oe = 1'b1;
        bad.xck_dev = 1'b0;
        bad.xck_dev_oe = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd_chk(`UF_OFS_CSA, 8'h20);
        rd_chk(`UF_OFS_CSB, `UF_RST_CSB);
        rd_chk(`UF_OFS_CSC, `UF_RST_CSC);
        rd_chk(`UF_OFS_BAUD, `UF_RST_BAUD);
        wr(3'h6, 8'hff);
        rd_chk(3'h6, 8'h00);
        wr(`UF_OFS_DATA, 8'h77);
        rd_chk(`UF_OFS_DATA, 8'h00);
        rd_chk(`UF_OFS_CSA, 8'h20);
        $display("test registers done");
        for (int s = 0; s < 5; s++)
            for (int p = 0; p < 3; p++)
                for (int t = 0; t < 2; t++)
                    send(9'h1a5 ^ 9'(s * 77 + p * 13 + t * 5), {2'b00, pcode[p], t[0], scode[s]}, 16);
        send(9'h0c3, 8'h13, 16);
        $display("test formats done");
        wr(`UF_OFS_CSA, 8'h42);
        p_dbl <= 1'b1;
        send(9'h03c, 8'h03, 8);
        wr(`UF_OFS_CSA, 8'h40);
        p_dbl <= 1'b0;
        $display("test double speed done");
        wr(`UF_OFS_BAUD, 8'h03);
        p_baud <= 8'h03;
        wr(`UF_OFS_CSB, 8'h28);
        tick(1);
        check({8'h00, irq}, 9'h001);
        va = frame_bits(9'h03c, 8, 2'h0, 1'b0, len);
        vb = frame_bits(9'h081, 8, 2'h0, 1'b0, len);
        wr(`UF_OFS_DATA, 8'h3c);
        // Step off the write edge so the request line has settled before polling
        #1;
        k = 0;
        while (irq !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        check(9'(k < 200), 9'h001);
        wr(`UF_OFS_DATA, 8'h81);
        #1;
        check({8'h00, irq}, 9'h000);
        rd_chk(`UF_OFS_CSA, 8'h00);
        watch(va, len, 64, k);
        watch(vb, len, 64, k);
        check(9'(k <= 33), 9'h001);
        tick(64);
        check(rx_data, 9'h081);
        rd_chk(`UF_OFS_CSA, 8'h60);
        wr(`UF_OFS_CSA, 8'h40);
        rd_chk(`UF_OFS_CSA, 8'h20);
        $display("test buffering done");
        send(9'h0e1, 8'h43, 0);
        check({8'h00, lnk.xck_dev_oe}, 9'h001);
        @(posedge clk_i);
        p_master <= 1'b1;
        send(9'h05a, 8'hc3, 0);
        check({8'h00, lnk.xck_dev_oe}, 9'h000);
        $display("test synchronous done");
        wr(`UF_OFS_CSC, 8'h03);
        p_sync <= 1'b0;
        p_master <= 1'b0;
        wr(`UF_OFS_BAUD, 8'h00);
        p_baud <= 8'h00;
        c0 = rx_cnt;
        wr(`UF_OFS_DATA, 8'h5a);
        wr(`UF_OFS_CSB, 8'h00);
        wait_rx(c0);
        check(rx_data, 9'h05a);
        tick(200);
        check({7'h00, lnk.txd_oe, lnk.txd_line}, 9'h001);
        c0 = rx_cnt;
        wr(`UF_OFS_DATA, 8'hff);
        tick(400);
        check(9'(rx_cnt - c0), 9'h000);
        $display("test disable done");
        p_par <= 2'h2;
        raw(12'h802);
        check({7'h00, fe2, pe2}, 9'h003);
        check(rx2_data, 9'h001);
        raw(12'he02);
        check({7'h00, fe2, pe2}, 9'h000);
        $display("test faulty frames done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> verification/uart_frame_props.sv
// Checker for the serial link between the transmitter and its partner.
// Assumes one clock domain; inputs are the link interface signals.
`default_nettype none
module uart_frame_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic txd,
    input wire logic txd_oe,
    input wire logic xck_dev,
    input wire logic xck_dev_oe,
    input wire logic txd_line
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // No mode gives a bit shorter than two clocks, so that is the floor
    property p_start_held;
        $fell(txd) && txd_oe |=> !txd;
    endproperty
    a_start_held: assert property (p_start_held) else $error("start bit too short");

    property p_high_before_start;
        $fell(txd) && txd_oe |-> $past(txd, 2);
    endproperty
    a_high_before_start: assert property (p_high_before_start) else $error("no idle or stop");

    // Shortest frame is fourteen clocks, so the pin must stay owned
    property p_frame_keeps_pin;
        $fell(txd) && txd_oe |-> txd_oe [*8];
    endproperty
    a_frame_keeps_pin: assert property (p_frame_keeps_pin) else $error("pin lost mid frame");

    property p_low_bounded;
        $fell(txd) && txd_oe |-> ##[2:1000] txd;
    endproperty
    a_low_bounded: assert property (p_low_bounded) else $error("line stuck low");

    property p_release_idle;
        $fell(txd_oe) |-> $past(txd) && $past(txd, 2);
    endproperty
    a_release_idle: assert property (p_release_idle) else $error("released mid frame");

    property p_enable_idle;
        $rose(txd_oe) |-> txd;
    endproperty
    a_enable_idle: assert property (p_enable_idle) else $error("enable not idle high");

    property p_released_high;
        !txd_oe |-> txd_line;
    endproperty
    a_released_high: assert property (p_released_high) else $error("released line low");

    property p_clock_owner;
        xck_dev_oe |-> txd_oe;
    endproperty
    a_clock_owner: assert property (p_clock_owner) else $error("clock driven while off");

    property p_sample_stable;
        xck_dev_oe && $past(xck_dev_oe) && $fell(xck_dev) |-> $stable(txd);
    endproperty
    a_sample_stable: assert property (p_sample_stable) else $error("data moved at sample");
endmodule
`default_nettype wire
